// [rtl/fmch_pkg.sv]
package fmch_pkg;

  typedef enum logic [1:0] {WID_X1, WID_X2, WID_X4} fmch_width_t;

  localparam logic [7:0] CMD_WR_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_VOL_ENABLE = 8'h50;
  localparam logic [7:0] CMD_WR_STATUS  = 8'h01;
  localparam logic [7:0] CMD_RD_STATUS  = 8'h05;
  localparam logic [7:0] CMD_RST_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RST_DO     = 8'h99;
  localparam logic [7:0] CMD_ADDR4_IN   = 8'hB7;
  localparam logic [7:0] CMD_ADDR4_OUT  = 8'hE9;
  localparam logic [7:0] CMD_PARAM_RD   = 8'h5A;

  localparam logic [23:0] PT_SR_ADDR   = 24'h00006C;
  localparam logic [23:0] PT_RST_ADDR  = 24'h00006D;
  localparam logic [23:0] PT_EX4_ADDR  = 24'h00006E;
  localparam logic [23:0] PT_EN4_ADDR  = 24'h00006F;
  localparam logic [7:0]  PT_SR_VAL    = 8'hE8;
  localparam logic [7:0]  PT_RST_VAL   = 8'h50;
  localparam logic [7:0]  PT_EX4_VAL   = 8'hC1;
  localparam logic [7:0]  PT_EN4_VAL   = 8'hA5;
  localparam logic [7:0]  PT_FILL      = 8'hFF;

  localparam logic [1:0] PARAM_ADDR_BYTES = 2'h3;
  localparam logic [2:0] ADDR_BYTES_3     = 3'h3;
  localparam logic [2:0] ADDR_BYTES_4     = 3'h4;
  localparam logic [2:0] NB_MAX           = 3'h7;
  localparam int         SR_WEL_BIT       = 1;
  localparam logic [7:0] SR_RESET         = 8'h00;

endpackage : fmch_pkg

// [rtl/fmch_link_if.sv]
`timescale 1ns/1ps
interface fmch_link_if;
  logic                   byte_vld;
  logic [7:0]             rx_byte;
  logic                   tx_load;
  logic [7:0]             tx_byte;
  logic                   out_en;
  fmch_pkg::fmch_width_t  width;

  modport core  (input byte_vld, rx_byte, output tx_load, tx_byte, out_en, width);
  modport shift (output byte_vld, rx_byte, input tx_load, tx_byte, out_en, width);
endinterface : fmch_link_if

// [rtl/fmch_shift.sv]
`timescale 1ns/1ps
module fmch_shift (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic [3:0]  dq_i,
  output logic      [3:0]  dq_o,
  output logic      [3:0]  dq_oe,
  fmch_link_if.shift       lnk
);
  logic       sck_r, sck_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] rx_r, rx_nxt, tx_r, tx_nxt;
  logic [7:0] rxb_r, rxb_nxt;
  logic       vld_r, vld_nxt;
  logic [3:0] out_r, out_nxt;
  logic [3:0] step, sum;
  logic [7:0] shin;
  logic       rise, fall;

  always_comb begin
    rise = sck & ~sck_r;
    fall = ~sck & sck_r;
    unique case (lnk.width)
      fmch_pkg::WID_X1: begin
        step = 4'h1;
        shin = {rx_r[6:0], dq_i[0]};
      end
      fmch_pkg::WID_X2: begin
        step = 4'h2;
        shin = {rx_r[5:0], dq_i[1:0]};
      end
      default: begin
        step = 4'h4;
        shin = {rx_r[3:0], dq_i};
      end
    endcase
    sum     = {1'b0, cnt_r} + step;
    sck_nxt = sck;
    cnt_nxt = cnt_r;
    rx_nxt  = rx_r;
    rxb_nxt = rxb_r;
    vld_nxt = 1'b0;
    tx_nxt  = tx_r;
    out_nxt = out_r;
    if (cs_n) begin
      cnt_nxt = 3'h0;
    end else if (rise) begin
      rx_nxt  = shin;
      cnt_nxt = sum[2:0];
      if (sum[3]) begin
        rxb_nxt = shin;
        vld_nxt = 1'b1;
      end
    end
    if (lnk.tx_load) begin
      tx_nxt = lnk.tx_byte;
    end else if (fall && !cs_n) begin
      // Lane use follows the current interface width
      unique case (lnk.width)
        fmch_pkg::WID_X1: out_nxt = {2'h0, tx_r[7], 1'b0};
        fmch_pkg::WID_X2: out_nxt = {2'h0, tx_r[7:6]};
        default:          out_nxt = tx_r[7:4];
      endcase
      tx_nxt = tx_r << step;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sck_r <= 1'b0;
      cnt_r <= 3'h0;
      rx_r  <= 8'h00;
      rxb_r <= 8'h00;
      vld_r <= 1'b0;
      tx_r  <= 8'h00;
      out_r <= 4'h0;
    end else begin
      sck_r <= sck_nxt;
      cnt_r <= cnt_nxt;
      rx_r  <= rx_nxt;
      rxb_r <= rxb_nxt;
      vld_r <= vld_nxt;
      tx_r  <= tx_nxt;
      out_r <= out_nxt;
    end
  end

  always_comb begin
    lnk.byte_vld = vld_r;
    lnk.rx_byte  = rxb_r;
    dq_o         = out_r;
    dq_oe        = 4'h0;
    if (lnk.out_en && !cs_n) begin
      unique case (lnk.width)
        fmch_pkg::WID_X1: dq_oe = 4'h2;
        fmch_pkg::WID_X2: dq_oe = 4'h3;
        default:          dq_oe = 4'hF;
      endcase
    end
  end
endmodule : fmch_shift

// [rtl/fmch_top.sv]
`timescale 1ns/1ps
// Overview of operation
// RQ1: Power-up reset loads the status register from the stored nonvolatile value.
// RQ2: Nonvolatile status write needs a prior 06h; otherwise it is refused.
// RQ3: 50h arms a volatile status write that overrides until power cycle.
// RQ4: Soft reset happens only when 99h directly follows 66h.
// RQ5: Reset pair accepted at the current 1, 2 or 4 line width.
// RQ6: E9h returns to 3-byte addressing without write enable.
// RQ7: B7h enters 4-byte addressing without write enable.
// RQ8: Parameter table gives E8h at 6Ch and 50h at 6Dh.
// RQ9: Addressed commands carry four address bytes in 4-byte mode, else three; here 5Ah always takes three, and addr_bytes only reports the count.
module fmch_top (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   sck,
  input  wire logic                   cs_n,
  input  wire logic [3:0]             dq_i,
  output logic      [3:0]             dq_o,
  output logic      [3:0]             dq_oe,
  input  wire fmch_pkg::fmch_width_t  io_mode,
  input  wire logic [7:0]             nv_sr_stored,
  output logic                        nv_sr_wr,
  output logic      [7:0]             nv_sr_wdata,
  output logic      [7:0]             status_q,
  output logic                        addr4_mode,
  output logic      [2:0]             addr_bytes,
  output logic                        soft_rst_p
);
  typedef enum {ST_CMD, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA, ST_SKIP} fmch_state_t;

  fmch_link_if lnk ();

  fmch_shift u_shift (
    .core_clk (core_clk),
    .rst      (rst),
    .sck      (sck),
    .cs_n     (cs_n),
    .dq_i     (dq_i),
    .dq_o     (dq_o),
    .dq_oe    (dq_oe),
    .lnk      (lnk.shift)
  );

  fmch_state_t st_r, st_nxt;
  logic [7:0]  cmd_r, cmd_nxt, wdat_r, wdat_nxt, sr_r, sr_nxt, nvd_r, nvd_nxt;
  logic [7:0]  tx_r, tx_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [1:0]  acnt_r, acnt_nxt;
  logic [2:0]  nb_r, nb_nxt;
  logic        cs_r, wel_r, wel_nxt, vwe_r, vwe_nxt, vol_r, vol_nxt;
  logic        rsten_r, rsten_nxt, addr4_r, addr4_nxt, srst_r, srst_nxt;
  logic        nvw_r, nvw_nxt, ld_r, ld_nxt;
  logic        frame_end, one_byte;
  logic [7:0]  sr_view;

  function automatic logic [7:0] pt_byte(input logic [23:0] a);
    unique case (a)
      fmch_pkg::PT_SR_ADDR:  pt_byte = fmch_pkg::PT_SR_VAL;
      fmch_pkg::PT_RST_ADDR: pt_byte = fmch_pkg::PT_RST_VAL;
      fmch_pkg::PT_EX4_ADDR: pt_byte = fmch_pkg::PT_EX4_VAL;
      fmch_pkg::PT_EN4_ADDR: pt_byte = fmch_pkg::PT_EN4_VAL;
      default:               pt_byte = fmch_pkg::PT_FILL;
    endcase
  endfunction : pt_byte

  always_comb begin
    frame_end = cs_n & ~cs_r;
    one_byte  = (nb_r == 3'h1);
    sr_view   = sr_r;
    sr_view[fmch_pkg::SR_WEL_BIT] = wel_r;
    lnk.width   = io_mode; // [RQ5]
    lnk.out_en  = (st_r == ST_RDATA);
    lnk.tx_load = ld_r;
    lnk.tx_byte = tx_r;
  end

  always_comb begin
    st_nxt = st_r;      cmd_nxt = cmd_r;     wdat_nxt = wdat_r;   sr_nxt = sr_r;
    nvd_nxt = nvd_r;    tx_nxt = tx_r;       addr_nxt = addr_r;   acnt_nxt = acnt_r;
    nb_nxt = nb_r;      wel_nxt = wel_r;     vwe_nxt = vwe_r;     vol_nxt = vol_r;
    rsten_nxt = rsten_r; addr4_nxt = addr4_r;
    srst_nxt = 1'b0;
    nvw_nxt  = 1'b0;
    ld_nxt   = 1'b0;
    if (cs_n) begin
      st_nxt = ST_CMD;
      nb_nxt = 3'h0;
    end else if (lnk.byte_vld) begin
      nb_nxt = (nb_r == fmch_pkg::NB_MAX) ? nb_r : nb_r + 3'h1;
      unique case (st_r)
        ST_CMD: begin
          cmd_nxt = lnk.rx_byte;
          if (lnk.rx_byte == fmch_pkg::CMD_PARAM_RD) begin
            st_nxt   = ST_ADDR;
            acnt_nxt = fmch_pkg::PARAM_ADDR_BYTES;
          end else if (lnk.rx_byte == fmch_pkg::CMD_RD_STATUS) begin
            st_nxt = ST_RDATA;
            tx_nxt = sr_view;
            ld_nxt = 1'b1;
          end else if (lnk.rx_byte == fmch_pkg::CMD_WR_STATUS) begin
            st_nxt = ST_WDATA;
          end else begin
            st_nxt = ST_SKIP;
          end
        end
        ST_ADDR: begin
          addr_nxt = {addr_r[15:0], lnk.rx_byte};
          acnt_nxt = acnt_r - 2'h1;
          if (acnt_r == 2'h1) begin
            st_nxt = ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          st_nxt   = ST_RDATA;
          tx_nxt   = pt_byte(addr_r); // [RQ8]
          ld_nxt   = 1'b1;
          addr_nxt = addr_r + 24'h1;
        end
        ST_RDATA: begin
          ld_nxt = 1'b1;
          if (cmd_r == fmch_pkg::CMD_PARAM_RD) begin
            tx_nxt   = pt_byte(addr_r); // [RQ8]
            addr_nxt = addr_r + 24'h1;
          end else begin
            tx_nxt = sr_view;
          end
        end
        ST_WDATA: begin
          wdat_nxt = lnk.rx_byte;
          st_nxt   = ST_SKIP;
        end
        default: st_nxt = ST_SKIP;
      endcase
    end
    // Commands take effect at deselect, so a frame with no complete byte has no effect
    if (frame_end && nb_r != 3'h0) begin
      if (!(one_byte && cmd_r == fmch_pkg::CMD_RST_ENABLE)) begin
        rsten_nxt = 1'b0; // [RQ4]
      end
      if (!(one_byte && cmd_r == fmch_pkg::CMD_VOL_ENABLE)) begin
        vwe_nxt = 1'b0;
      end
      if (one_byte) begin
        unique case (cmd_r)
          fmch_pkg::CMD_WR_ENABLE:  wel_nxt = 1'b1; // [RQ2]
          fmch_pkg::CMD_VOL_ENABLE: vwe_nxt = 1'b1; // [RQ3]
          fmch_pkg::CMD_ADDR4_IN:   addr4_nxt = 1'b1; // [RQ7]
          fmch_pkg::CMD_ADDR4_OUT:  addr4_nxt = 1'b0; // [RQ6]
          fmch_pkg::CMD_RST_ENABLE: rsten_nxt = 1'b1; // [RQ4]
          fmch_pkg::CMD_RST_DO: begin
            if (rsten_r) begin // [RQ4]
              // Volatile override survives a soft reset; only power-up clears it
              srst_nxt  = 1'b1;
              wel_nxt   = 1'b0;
              vwe_nxt   = 1'b0;
              addr4_nxt = 1'b0;
            end
          end
          default: ;
        endcase
      end else if (cmd_r == fmch_pkg::CMD_WR_STATUS && nb_r >= 3'h2) begin
        if (vwe_r) begin
          sr_nxt  = {wdat_r[7:2], 2'h0}; // [RQ3]
          vol_nxt = 1'b1;
        end else if (wel_r) begin
          nvw_nxt = 1'b1; // [RQ2]
          nvd_nxt = {wdat_r[7:2], 2'h0};
          wel_nxt = 1'b0;
          if (!vol_r) begin
            sr_nxt = {wdat_r[7:2], 2'h0}; // [RQ3]
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= ST_CMD;     cmd_r <= 8'h00;   wdat_r <= 8'h00;  nvd_r <= 8'h00;
      tx_r <= 8'h00;      addr_r <= 24'h0;  acnt_r <= 2'h0;   nb_r <= 3'h0;
      cs_r <= 1'b1;       wel_r <= 1'b0;    vwe_r <= 1'b0;    vol_r <= 1'b0;
      rsten_r <= 1'b0;    addr4_r <= 1'b0;  srst_r <= 1'b0;   nvw_r <= 1'b0;
      ld_r <= 1'b0;
      sr_r <= nv_sr_stored; // [RQ1]
    end else begin
      st_r <= st_nxt;     cmd_r <= cmd_nxt; wdat_r <= wdat_nxt; nvd_r <= nvd_nxt;
      tx_r <= tx_nxt;     addr_r <= addr_nxt; acnt_r <= acnt_nxt; nb_r <= nb_nxt;
      cs_r <= cs_n;       wel_r <= wel_nxt; vwe_r <= vwe_nxt;  vol_r <= vol_nxt;
      rsten_r <= rsten_nxt; addr4_r <= addr4_nxt; srst_r <= srst_nxt; nvw_r <= nvw_nxt;
      ld_r <= ld_nxt;
      sr_r <= sr_nxt;
    end
  end

  always_comb begin
    nv_sr_wr    = nvw_r;
    nv_sr_wdata = nvd_r;
    status_q    = sr_view;
    addr4_mode  = addr4_r;
    addr_bytes  = addr4_r ? fmch_pkg::ADDR_BYTES_4 : fmch_pkg::ADDR_BYTES_3; // [RQ9]
    soft_rst_p  = srst_r;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_boot_from_nv: assert property (@(posedge core_clk) disable iff (1'b0) // [RQ1]
    rst |=> sr_r == $past(nv_sr_stored)) else $error("status not loaded from nv copy");
  a_nv_needs_wel: assert property (nv_sr_wr |-> $past(wel_r) && !wel_r) // [RQ2]
    else $error("nv status written without write enable");
  a_vol_armed: assert property ($rose(vol_r) |-> $past(vwe_r) && !nv_sr_wr) // [RQ3]
    else $error("volatile copy activated without 50h");
  a_vol_overrides: assert property (vol_r && nv_sr_wr |-> $stable(sr_r)) // [RQ3]
    else $error("nv write disturbed active volatile status");
  a_reset_pair: assert property (soft_rst_p |-> $past(rsten_r) && // [RQ4]
    $past(cmd_r) == fmch_pkg::CMD_RST_DO && $past(nb_r) == 3'h1)
    else $error("soft reset without directly preceding 66h");
  a_quad_lanes: assert property (io_mode == fmch_pkg::WID_X4 && |dq_oe // [RQ5]
    |-> dq_oe == 4'hF) else $error("output lanes do not match width");
  a_exit_4b: assert property (frame_end && one_byte && // [RQ6]
    cmd_r == fmch_pkg::CMD_ADDR4_OUT |=> !addr4_mode) else $error("E9h did not exit");
  a_enter_4b: assert property (frame_end && one_byte && // [RQ7]
    cmd_r == fmch_pkg::CMD_ADDR4_IN |=> addr4_mode) else $error("B7h did not enter");
  a_table_sr: assert property (ld_nxt && cmd_r == fmch_pkg::CMD_PARAM_RD && // [RQ8]
    st_r != ST_CMD && addr_r == fmch_pkg::PT_SR_ADDR |=> tx_r == fmch_pkg::PT_SR_VAL)
    else $error("wrong table byte at 6Ch");
  a_addr_change: assert property ($changed(addr4_mode) |-> $past(frame_end)) // [RQ9]
    else $error("address mode changed outside deselect");

  c_soft_reset: cover property (soft_rst_p);
  c_nv_write:   cover property (nv_sr_wr);
  c_vol_active: cover property ($rose(vol_r));
  c_enter_4b:   cover property ($rose(addr4_mode));
endmodule : fmch_top

// [test/fmch_host.sv]
`timescale 1ns/1ps
module fmch_host (
  input  wire logic                   core_clk,
  input  wire fmch_pkg::fmch_width_t  io_mode,
  input  wire logic [3:0]             dq_o,
  output logic                        sck,
  output logic                        cs_n,
  output logic      [3:0]             dq_i
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];

  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    dq_i = 4'hA;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // Four core cycles per sck level keeps clear of the three-cycle minimum
  task automatic frame(input int nrd);
    logic [7:0] b;
    int         w;
    rx_q.delete();
    @(posedge core_clk);
    w = (io_mode == fmch_pkg::WID_X4) ? 4 : (io_mode == fmch_pkg::WID_X2) ? 2 : 1;
    cs_n <= 1'b0;
    tick(3);
    while (tx_q.size() > 0) begin
      b = tx_q.pop_front();
      for (int i = 8 - w; i >= 0; i -= w) begin
        dq_i <= 4'((b >> i) & ((1 << w) - 1));
        tick(4);
        sck <= 1'b1;
        tick(4);
        sck <= 1'b0;
      end
    end
    for (int k = 0; k < nrd; k++) begin
      b = 8'h00;
      repeat (8) begin
        // Lines are not meaningful while reading, so they keep moving
        dq_i <= ~dq_i;
        tick(4);
        sck <= 1'b1;
        b = {b[6:0], dq_o[1]};
        tick(4);
        sck <= 1'b0;
      end
      rx_q.push_back(b);
    end
    tick(3);
    cs_n <= 1'b1;
    dq_i <= ~dq_i;
    tick(4);
  endtask : frame
endmodule : fmch_host

// [test/tb_fmch_top.sv]
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH %0t %s", $time, msg); end end
module tb_fmch_top;
  logic                   core_clk     = 1'b0;
  logic                   rst          = 1'b1;
  fmch_pkg::fmch_width_t  io_mode      = fmch_pkg::WID_X1;
  logic [7:0]             nv_sr_stored = 8'h00;
  logic                   sck, cs_n, nv_sr_wr, addr4_mode, soft_rst_p;
  logic [3:0]             dq_i, dq_o, dq_oe;
  logic [7:0]             nv_sr_wdata, status_q, last_wd, m_stat;
  logic [2:0]             addr_bytes;
  logic                   m_wel, m_vol, m_a4, arm50, arm66;
  int                     err_total, num_checks, nvw_cnt, srst_cnt, m_nvw, m_rst;
  integer                 seed;
  logic [7:0]             wseq[8] = '{8'h01, 8'h06, 8'h01, 8'h50, 8'h01, 8'h06, 8'h01, 8'h06};
  logic [7:0]             rseq[9] = '{8'hB7, 8'h66, 8'h99, 8'hB7, 8'h66, 8'h06, 8'h99, 8'h99,
                                      8'hE9};

  always #50 core_clk = ~core_clk;

  fmch_top i_fmch_top (.core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe(dq_oe), .io_mode(io_mode), .nv_sr_stored(nv_sr_stored),
    .nv_sr_wr(nv_sr_wr), .nv_sr_wdata(nv_sr_wdata), .status_q(status_q),
    .addr4_mode(addr4_mode), .addr_bytes(addr_bytes), .soft_rst_p(soft_rst_p));

  fmch_host i_fmch_host (.core_clk(core_clk), .io_mode(io_mode), .dq_o(dq_o), .sck(sck),
    .cs_n(cs_n), .dq_i(dq_i));

  // A pulse that stands too long is counted more than once
  always @(posedge core_clk) begin
    if (nv_sr_wr === 1'b1) begin
      nvw_cnt++;
      last_wd = nv_sr_wdata;
    end
    if (soft_rst_p === 1'b1) srst_cnt++;
    // Reads run only in single-line mode, so one lane or none
    if (!rst && (cs_n === 1'b1 || dq_oe !== 4'h0))
      `CHK(dq_oe, (cs_n ? 4'h0 : 4'h2), "lane enables")
  end

  task automatic print_verdict();
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic check_all();
    `CHK(status_q, {m_stat[7:2], m_wel, 1'b0}, "status")
    `CHK(addr4_mode, m_a4, "address mode")
    `CHK(addr_bytes, (m_a4 ? 3'h4 : 3'h3), "address bytes")
    `CHK(nvw_cnt, m_nvw, "stored writes")
    `CHK(srst_cnt, m_rst, "soft resets")
  endtask : check_all

  task automatic send(input logic [7:0] op, input logic [7:0] d, input bit wd);
    i_fmch_host.tx_q.push_back(op);
    if (wd) i_fmch_host.tx_q.push_back(d);
    i_fmch_host.frame(0);
    repeat (4) @(posedge core_clk);
    if (wd && arm50) begin
      m_stat = d;
      m_vol  = 1'b1;
    end else if (wd && m_wel) begin
      m_nvw++;
      m_wel = 1'b0;
      if (!m_vol) m_stat = d;
      `CHK(last_wd, {d[7:2], 2'b00}, "stored value")
    end
    if (op == 8'h06) m_wel = 1'b1;
    if (op == 8'h99 && arm66) begin
      m_rst++;
      m_a4  = 1'b0;
      m_wel = 1'b0;
    end
    if (op == 8'hB7) m_a4 = 1'b1;
    if (op == 8'hE9) m_a4 = 1'b0;
    arm50 = (op == 8'h50);
    arm66 = (op == 8'h66);
    check_all();
  endtask : send

  task automatic read_back(input int nrd);
    i_fmch_host.frame(nrd);
    repeat (4) @(posedge core_clk);
    arm50 = 1'b0;
    arm66 = 1'b0;
  endtask : read_back

  initial begin
    #5_000_000;
    err_total++;
    print_verdict();
  end

  initial begin
    seed = 32'h1346;
    @(posedge core_clk);
    nv_sr_stored <= 8'($random(seed)) & 8'hFC;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    m_stat = nv_sr_stored;
    {m_wel, m_vol, m_a4, arm50, arm66} = 5'h00;
    repeat (3) @(posedge core_clk);
    `CHK(status_q, nv_sr_stored, "power-up status")
    // First write lacks the enable and must be refused
    foreach (wseq[i]) send(wseq[i], 8'($random(seed)), wseq[i] == 8'h01);
    i_fmch_host.tx_q.push_back(8'h05);
    read_back(2);
    `CHK(i_fmch_host.rx_q[1], {m_stat[7:2], m_wel, 1'b0}, "status read")
    for (int m = 0; m < 3; m++) begin
      io_mode <= fmch_pkg::fmch_width_t'(m);
      foreach (rseq[i]) send(rseq[i], 8'h00, 1'b0);
    end
    io_mode <= fmch_pkg::WID_X1;
    for (int k = 0; k < 2; k++) begin
      if (k == 1) send(8'hB7, 8'h00, 1'b0);
      i_fmch_host.tx_q = '{8'h5A, 8'h00, 8'h00, 8'h6B, 8'h00};
      read_back(3);
      `CHK(i_fmch_host.rx_q[1], 8'hE8, "volatility byte")
      `CHK(i_fmch_host.rx_q[2], 8'h50, "soft reset byte")
    end
    send(8'hE9, 8'h00, 1'b0);
    // Power cycle: stored copy holds the last write, volatile override is gone
    nv_sr_stored <= last_wd;
    rst          <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(status_q, last_wd, "status after power cycle")
    print_verdict();
  end
endmodule : tb_fmch_top
